//--- src/csdec_pkg.sv
// ====================================================================
// Chip select decoder constants
package csdec_pkg;

  // ==================================================================
  // Register offsets (byte addresses on APB)
  localparam logic [7:0] CSDEC_CTRL_OFF = 8'h00;
  localparam logic [7:0] CSDEC_STRETCH_OFF = 8'h04;
  localparam logic [7:0] CSDEC_GP1_OFF = 8'h08;
  localparam logic [7:0] CSDEC_GP2_OFF = 8'h0C;
  localparam logic [7:0] CSDEC_STATUS_OFF = 8'h10;

  // ==================================================================
  // Control register fields
  localparam int CSDEC_IO_EN_BIT = 0;
  localparam int CSDEC_IO_PHASE_BIT = 1;
  localparam int CSDEC_IO_POL_BIT = 2;
  localparam int CSDEC_IO_SIZE_BIT = 3;
  localparam int CSDEC_PROG_EN_BIT = 4;
  localparam int CSDEC_PROG_SIZE_LSB = 5;
  localparam int CSDEC_PRIO_BIT = 7;
  localparam logic [7:0] CSDEC_CTRL_RESET = 8'h10;

  // ==================================================================
  // Stretch register: two bits per select, io, prog, gp1, gp2
  localparam logic [7:0] CSDEC_STRETCH_RESET = 8'h00;

  // ==================================================================
  // General select register fields
  localparam int CSDEC_GP_BASE_LSB = 0;
  localparam int CSDEC_GP_SIZE_LSB = 8;
  localparam int CSDEC_GP_POL_BIT = 16;
  localparam int CSDEC_GP_PHASE_BIT = 17;
  localparam logic [17:0] CSDEC_GP_RESET = 18'h00000;

  // ==================================================================
  // Fixed address windows
  localparam logic [15:0] CSDEC_IO_LO_4K = 16'h1000;
  localparam logic [15:0] CSDEC_IO_LO_8K = 16'h0000;
  localparam logic [15:0] CSDEC_IO_HI = 16'h1FFF;
  localparam logic [15:0] CSDEC_PROG_LO_64K = 16'h0000;
  localparam logic [15:0] CSDEC_PROG_LO_32K = 16'h8000;
  localparam logic [15:0] CSDEC_PROG_LO_16K = 16'hC000;
  localparam logic [15:0] CSDEC_PROG_LO_8K = 16'hE000;
  localparam logic [15:0] CSDEC_PROG_HI = 16'hFFFF;

  // ==================================================================
  // Select index on port H pins 4 to 7
  localparam int CSDEC_SEL_IO = 0;
  localparam int CSDEC_SEL_PROG = 1;
  localparam int CSDEC_SEL_GP1 = 2;
  localparam int CSDEC_SEL_GP2 = 3;

  // Access sequencer states
  typedef enum logic [1:0] {
    CSDEC_IDLE = 2'b00,
    CSDEC_ACCESS = 2'b01,
    CSDEC_STRETCH = 2'b10
  } csdec_state_t;

endpackage : csdec_pkg

//--- src/csdec_range.sv
`timescale 1ns/1ps
// ====================================================================
// Inclusive address range compare
module csdec_range #(
  parameter int W = 16
) (
  // Address and bounds
  input wire logic [W-1:0] addr_i,
  input wire logic [W-1:0] lo_i,
  input wire logic [W-1:0] hi_i,
  // Window enable and result
  input wire logic en_i,
  output logic hit_o
);

  // Hit when enabled and inside the bounds
  always_comb
  begin
    hit_o = en_i && (addr_i >= lo_i) && (addr_i <= hi_i);
  end

endmodule : csdec_range

//--- src/csdec_top.sv
`timescale 1ns/1ps
// How it works
// [R1] A select asserts when the CPU accesses its programmed range.
// [R2] Selects work only in expanded mode; never assert in single-chip mode.
// [R3] Program select covers the top of the 64K map with reset vectors.
// [R4] I/O select decodes only within the first 8K of the map.
// [R5] General selects decode anywhere in the 1M expanded space.
// [R6] Port H pins 4-7 are GPIO when not used as a select.
// [R7] I/O enable bit: 1 enables, 0 disables; resets to 0.
// [R8] I/O phase bit: 1 address valid, 0 E high only; resets 0.
// [R9] I/O polarity bit: 1 active high, 0 active low; resets 0.
// [R10] I/O size bit: 1 gives 1000h-1FFFh, 0 gives 0000h-1FFFh.
// [R11] Each select stretches its cycle 0 to 3 E clocks; I/O resets 0.
// [R12] Program enable bit: 1 enables, 0 disables; resets to 1.
// [R13] Program size: 64K, 32K at 8000h, 16K at C000h, 8K at E000h.
// [R14] Priority bit: 1 general select wins overlap, 0 program select wins.
// [R15] A stretched cycle holds the select for the extra E clocks.
// [R16] External devices answer only while selected, within the stretched cycle.
module csdec_top
  import csdec_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // CPU bus side
  input wire logic [19:0] cpu_addr_i,
  input wire logic cpu_valid_i,
  input wire logic e_clk_i,
  input wire logic expanded_mode_i,
  output logic stretch_hold_o,
  // Port H pins 4 to 7
  input wire logic [3:0] ph_gpio_out_i,
  input wire logic [3:0] ph_gpio_oe_i,
  output logic [3:0] ph_out_o,
  output logic [3:0] ph_oe_b_o
);

  // ==================================================================
  // Declarations
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] stretch_reg, stretch_next;
  logic [17:0] gp1_reg, gp1_next;
  logic [17:0] gp2_reg, gp2_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic mode_meta_reg, mode_sync_reg;
  csdec_state_t state_reg, state_next;
  logic [3:0] sel_reg, sel_next;
  logic [1:0] cnt_reg, cnt_next;
  logic hold_reg, hold_next;
  logic valid_d_reg, e_d_reg;
  logic [3:0] ph_out_reg, ph_out_next;
  logic [3:0] ph_oe_b_reg, ph_oe_b_next;
  logic [15:0] io_lo, prog_lo;
  logic [19:0] gp1_lo, gp1_hi, gp2_lo, gp2_hi;
  logic [3:0] raw_hit, win_hit, sel_en, sel_pol, sel_phase, sel_act;
  logic mapped, wr_en;

  // ==================================================================
  // Mode strap synchroniser
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end
    else
    begin
      mode_meta_reg <= expanded_mode_i;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // ==================================================================
  // APB slave: answer in the first access cycle
  always_comb
  begin
    mapped = (paddr_i == CSDEC_CTRL_OFF) || (paddr_i == CSDEC_STRETCH_OFF) ||
             (paddr_i == CSDEC_GP1_OFF) || (paddr_i == CSDEC_GP2_OFF) ||
             (paddr_i == CSDEC_STATUS_OFF);
    wr_en = psel_i && penable_i && pready_reg && pwrite_i && !pslverr_reg;
    pready_next = psel_i && !penable_i;
    pslverr_next = psel_i && !penable_i && !mapped;
    prdata_next = prdata_reg;
    if (psel_i && !penable_i)
    begin
      case (paddr_i)
        CSDEC_CTRL_OFF: prdata_next = {24'h000000, ctrl_reg};
        CSDEC_STRETCH_OFF: prdata_next = {24'h000000, stretch_reg};
        CSDEC_GP1_OFF: prdata_next = {14'h0000, gp1_reg};
        CSDEC_GP2_OFF: prdata_next = {14'h0000, gp2_reg};
        CSDEC_STATUS_OFF: prdata_next = {26'h0000000, hold_reg, sel_reg, mode_sync_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  // Configuration writes
  always_comb
  begin
    ctrl_next = ctrl_reg;
    stretch_next = stretch_reg;
    gp1_next = gp1_reg;
    gp2_next = gp2_reg;
    if (wr_en)
    begin
      case (paddr_i)
        CSDEC_CTRL_OFF: ctrl_next = pwdata_i[7:0]; // R1
        CSDEC_STRETCH_OFF: stretch_next = pwdata_i[7:0]; // R11
        CSDEC_GP1_OFF: gp1_next = pwdata_i[17:0];
        CSDEC_GP2_OFF: gp2_next = pwdata_i[17:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  // Bus and configuration registers
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      ctrl_reg <= CSDEC_CTRL_RESET; // R7 R8 R9 R10 R12 R13 R14
      stretch_reg <= CSDEC_STRETCH_RESET; // R11
      gp1_reg <= CSDEC_GP_RESET;
      gp2_reg <= CSDEC_GP_RESET;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      ctrl_reg <= ctrl_next;
      stretch_reg <= stretch_next;
      gp1_reg <= gp1_next;
      gp2_reg <= gp2_next;
    end
  end

  // ==================================================================
  // Window bounds
  always_comb
  begin
    io_lo = ctrl_reg[CSDEC_IO_SIZE_BIT] ? CSDEC_IO_LO_4K : CSDEC_IO_LO_8K; // R10
    case (ctrl_reg[CSDEC_PROG_SIZE_LSB +: 2]) // R13
      2'h1: prog_lo = CSDEC_PROG_LO_32K;
      2'h2: prog_lo = CSDEC_PROG_LO_16K;
      2'h3: prog_lo = CSDEC_PROG_LO_8K;
      default: prog_lo = CSDEC_PROG_LO_64K;
    endcase
  end

  // General windows: base and size in 4K blocks, clipped at the top
  function automatic logic [19:0] gp_hi(input logic [17:0] cfg);
    logic [20:0] last;
    last = {1'b0, cfg[CSDEC_GP_BASE_LSB +: 8], 12'h000} +
           {1'b0, cfg[CSDEC_GP_SIZE_LSB +: 8], 12'h000} - 21'h000001;
    gp_hi = last[20] ? 20'hFFFFF : last[19:0];
  endfunction : gp_hi

  assign gp1_lo = {gp1_reg[CSDEC_GP_BASE_LSB +: 8], 12'h000};
  assign gp2_lo = {gp2_reg[CSDEC_GP_BASE_LSB +: 8], 12'h000};
  assign gp1_hi = gp_hi(gp1_reg);
  assign gp2_hi = gp_hi(gp2_reg);

  // Per select enable, polarity and phase
  always_comb
  begin
    sel_en[CSDEC_SEL_IO] = ctrl_reg[CSDEC_IO_EN_BIT]; // R7
    sel_en[CSDEC_SEL_PROG] = ctrl_reg[CSDEC_PROG_EN_BIT]; // R12
    sel_en[CSDEC_SEL_GP1] = gp1_reg[CSDEC_GP_SIZE_LSB +: 8] != 8'h00;
    sel_en[CSDEC_SEL_GP2] = gp2_reg[CSDEC_GP_SIZE_LSB +: 8] != 8'h00;
    sel_pol[CSDEC_SEL_IO] = ctrl_reg[CSDEC_IO_POL_BIT]; // R9
    sel_pol[CSDEC_SEL_PROG] = 1'b0;
    sel_pol[CSDEC_SEL_GP1] = gp1_reg[CSDEC_GP_POL_BIT];
    sel_pol[CSDEC_SEL_GP2] = gp2_reg[CSDEC_GP_POL_BIT];
    sel_phase[CSDEC_SEL_IO] = ctrl_reg[CSDEC_IO_PHASE_BIT]; // R8
    sel_phase[CSDEC_SEL_PROG] = 1'b1;
    sel_phase[CSDEC_SEL_GP1] = gp1_reg[CSDEC_GP_PHASE_BIT];
    sel_phase[CSDEC_SEL_GP2] = gp2_reg[CSDEC_GP_PHASE_BIT];
  end

  // ==================================================================
  // Range compares
  csdec_range #(.W(16)) u_io_range (
    .addr_i(cpu_addr_i[15:0]),
    .lo_i(io_lo),
    .hi_i(CSDEC_IO_HI),
    .en_i(sel_en[CSDEC_SEL_IO]),
    .hit_o(raw_hit[CSDEC_SEL_IO])
  ); // R4

  csdec_range #(.W(16)) u_prog_range (
    .addr_i(cpu_addr_i[15:0]),
    .lo_i(prog_lo),
    .hi_i(CSDEC_PROG_HI),
    .en_i(sel_en[CSDEC_SEL_PROG]),
    .hit_o(raw_hit[CSDEC_SEL_PROG])
  ); // R3

  csdec_range #(.W(20)) u_gp1_range (
    .addr_i(cpu_addr_i),
    .lo_i(gp1_lo),
    .hi_i(gp1_hi),
    .en_i(sel_en[CSDEC_SEL_GP1]),
    .hit_o(raw_hit[CSDEC_SEL_GP1])
  ); // R5

  csdec_range #(.W(20)) u_gp2_range (
    .addr_i(cpu_addr_i),
    .lo_i(gp2_lo),
    .hi_i(gp2_hi),
    .en_i(sel_en[CSDEC_SEL_GP2]),
    .hit_o(raw_hit[CSDEC_SEL_GP2])
  ); // R5

  // Overlap resolution: I/O first, then program versus general
  always_comb
  begin
    win_hit = raw_hit;
    if (raw_hit[CSDEC_SEL_IO])
    begin
      win_hit = 4'h1;
    end
    else if (ctrl_reg[CSDEC_PRIO_BIT])
    begin
      if (raw_hit[CSDEC_SEL_GP1] || raw_hit[CSDEC_SEL_GP2])
      begin
        win_hit[CSDEC_SEL_PROG] = 1'b0; // R14
      end
    end
    else if (raw_hit[CSDEC_SEL_PROG])
    begin
      win_hit[CSDEC_SEL_GP1] = 1'b0; // R14
      win_hit[CSDEC_SEL_GP2] = 1'b0;
    end
    if (raw_hit[CSDEC_SEL_GP1] && win_hit[CSDEC_SEL_GP2])
    begin
      win_hit[CSDEC_SEL_GP2] = 1'b0;
    end
  end

  // ==================================================================
  // Access sequencer with E clock stretching
  always_comb
  begin
    state_next = state_reg;
    sel_next = sel_reg;
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    case (state_reg)
      CSDEC_IDLE:
      begin
        hold_next = 1'b0;
        if (cpu_valid_i && !valid_d_reg)
        begin
          sel_next = mode_sync_reg ? win_hit : 4'h0; // R1 R2
          cnt_next = 2'h0;
          for (int i = 0; i < 4; i++)
          begin
            if (win_hit[i] && mode_sync_reg)
            begin
              cnt_next = stretch_reg[2*i +: 2]; // R11
            end
          end
          state_next = CSDEC_ACCESS;
        end
      end
      CSDEC_ACCESS:
      begin
        if (e_d_reg && !e_clk_i)
        begin
          if (cnt_reg != 2'h0)
          begin
            cnt_next = cnt_reg - 2'h1;
            hold_next = 1'b1; // R15
            state_next = CSDEC_STRETCH;
          end
          else
          begin
            sel_next = 4'h0;
            state_next = CSDEC_IDLE;
          end
        end
        else if (!cpu_valid_i)
        begin
          sel_next = 4'h0;
          state_next = CSDEC_IDLE;
        end
      end
      CSDEC_STRETCH:
      begin
        if (e_d_reg && !e_clk_i)
        begin
          if (cnt_reg != 2'h0)
          begin
            cnt_next = cnt_reg - 2'h1; // R15
          end
          else
          begin
            hold_next = 1'b0;
            sel_next = 4'h0;
            state_next = CSDEC_IDLE;
          end
        end
      end
      default:
      begin
        state_next = CSDEC_IDLE;
        sel_next = 4'h0;
        hold_next = 1'b0;
      end
    endcase
  end

  // Select qualified by phase: address valid or E high
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      sel_act[i] = sel_reg[i] && mode_sync_reg &&
                   (sel_phase[i] ? (cpu_valid_i || hold_reg) : e_clk_i); // R8 R15
    end
  end

  // Port H pin drive: select when assigned, else GPIO
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (mode_sync_reg && sel_en[i]) // R2
      begin
        ph_out_next[i] = sel_pol[i] ? sel_act[i] : !sel_act[i]; // R9
        ph_oe_b_next[i] = 1'b0;
      end
      else
      begin
        ph_out_next[i] = ph_gpio_out_i[i]; // R6
        ph_oe_b_next[i] = !ph_gpio_oe_i[i];
      end
    end
  end

  // Sequencer and pin registers
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= CSDEC_IDLE;
      sel_reg <= 4'h0;
      cnt_reg <= 2'h0;
      hold_reg <= 1'b0;
      valid_d_reg <= 1'b0;
      e_d_reg <= 1'b0;
      ph_out_reg <= 4'h0;
      ph_oe_b_reg <= 4'hF;
    end
    else
    begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      valid_d_reg <= cpu_valid_i;
      e_d_reg <= e_clk_i;
      ph_out_reg <= ph_out_next;
      ph_oe_b_reg <= ph_oe_b_next;
    end
  end

  // ==================================================================
  // Outputs
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign stretch_hold_o = hold_reg;
  assign ph_out_o = ph_out_reg;
  assign ph_oe_b_o = ph_oe_b_reg;

endmodule : csdec_top

//--- tb/csdec_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the chip select decoder
module csdec_chk
  import csdec_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // APB side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Bus and pins
  input wire logic e_clk_i,
  input wire logic expanded_mode_i,
  input wire logic stretch_hold_o,
  input wire logic [3:0] ph_gpio_out_i,
  input wire logic [3:0] ph_gpio_oe_i,
  input wire logic [3:0] ph_out_o,
  input wire logic [3:0] ph_oe_b_o
);
  logic e_d;
  logic [2:0] fall_cnt;
  logic mapped;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // Counts E falling edges seen while the hold is up
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      e_d <= 1'b0;
      fall_cnt <= 3'h0;
    end
    else
    begin
      e_d <= e_clk_i;
      if (!stretch_hold_o)
        fall_cnt <= 3'h0;
      else if (e_d && !e_clk_i && fall_cnt != 3'h7)
        fall_cnt <= fall_cnt + 3'h1;
    end
  end

  // Decoded register space
  assign mapped = paddr_i inside {CSDEC_CTRL_OFF, CSDEC_STRETCH_OFF, CSDEC_GP1_OFF,
                                  CSDEC_GP2_OFF, CSDEC_STATUS_OFF};

  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready_o |-> pslverr_o == !mapped)
    else $error("error flag wrong for address");
  a_err_data_zero: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  a_single_chip_data: assert property (!expanded_mode_i [*4] |->
    ph_out_o == $past(ph_gpio_out_i))
    else $error("pin level not from port data");
  a_single_chip_oe: assert property (!expanded_mode_i [*4] |->
    ph_oe_b_o == ~$past(ph_gpio_oe_i))
    else $error("pin enable not from port data");
  a_hold_bound: assert property (fall_cnt <= 3'h3)
    else $error("stretch longer than three E clocks");
  a_hold_mode: assert property ($rose(stretch_hold_o) |-> $past(expanded_mode_i, 3))
    else $error("stretch outside expanded mode");

  // Main scenarios
  c_stretch: cover property (stretch_hold_o);
  c_refused: cover property (pready_o && pslverr_o);
  c_gp_pin: cover property (expanded_mode_i && !ph_oe_b_o[2]);
endmodule : csdec_chk

bind csdec_top csdec_chk u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .e_clk_i(e_clk_i), .expanded_mode_i(expanded_mode_i),
  .stretch_hold_o(stretch_hold_o), .ph_gpio_out_i(ph_gpio_out_i),
  .ph_gpio_oe_i(ph_gpio_oe_i), .ph_out_o(ph_out_o), .ph_oe_b_o(ph_oe_b_o));

//--- tb/csdec_ext_dev.sv
`timescale 1ns/1ps
// ==========================================
// External device on one select pin
module csdec_ext_dev (
  // Pin and its active level
  input wire logic sel_i,
  input wire logic oe_b_i,
  input wire logic act_hi_i,
  // Device is answering
  output logic sel_o
);
  // Answers only while driven at the active level
  assign sel_o = !oe_b_i && (sel_i == act_hi_i);
endmodule : csdec_ext_dev

//--- tb/chip_select_decoder_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// Bench top
module chip_select_decoder_tb_top;
  import csdec_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [19:0] caddr = 20'h0;
  logic cval = 1'b0;
  logic expd = 1'b0;
  logic [3:0] go = 4'h0;
  logic [3:0] goe = 4'h0;
  logic [1:0] ecnt = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hold, dev_sel;
  logic [3:0] pout, poeb;
  logic [7:0] ctrl = 8'h10;
  logic [17:0] gp1 = 18'h0;
  logic [17:0] gp2 = 18'h0;
  int fails = 0;
  int cmp_count = 0;

  // Clock and free-running E clock
  always #5 mclk = ~mclk;
  always @(posedge mclk) ecnt <= ecnt + 2'h1;

  csdec_top dut (.mclk_i(mclk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cpu_addr_i(caddr), .cpu_valid_i(cval),
    .e_clk_i(ecnt[1]), .expanded_mode_i(expd), .stretch_hold_o(hold),
    .ph_gpio_out_i(go), .ph_gpio_oe_i(goe), .ph_out_o(pout), .ph_oe_b_o(poeb));
  csdec_ext_dev dev (.sel_i(pout[1]), .oe_b_i(poeb[1]), .act_hi_i(1'b0), .sel_o(dev_sel));

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      fails++;
      $display("[FAIL] %0t saw %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Expected pin enables and levels for an address
  function automatic logic [7:0] mdl(input logic [19:0] a, input logic act);
    logic [3:0] hit, asg, lvl;
    int gb, gs, hb, hs;
    gb = gp1[7:0];
    gs = gp1[15:8];
    hb = gp2[7:0];
    hs = gp2[15:8];
    hit[0] = ctrl[0] && a[15:0] >= (ctrl[3] ? 16'h1000 : 16'h0000) && a[15:0] <= 16'h1FFF;
    hit[1] = ctrl[4] && a[15:0] >= 65536 - (65536 >> ctrl[6:5]);
    hit[2] = gs != 0 && a[19:12] >= gb && a[19:12] < gb + gs;
    hit[3] = hs != 0 && a[19:12] >= hb && a[19:12] < hb + hs;
    if (hit[0])
      hit[3:1] = 3'h0;
    else if ((hit[2] || hit[3]) && ctrl[7])
      hit[1] = 1'b0;
    else if (hit[1])
      hit[3:2] = 2'h0;
    // First general select wins over the second
    if (hit[2])
      hit[3] = 1'b0;
    hit &= {4{act}};
    asg = {hs != 0, gs != 0, ctrl[4], ctrl[0]} & {4{expd}};
    lvl = {gp2[16], gp1[16], 1'b0, ctrl[2]};
    return {~asg & ~goe, (asg & ~(hit ^ lvl)) | (~asg & go)};
  endfunction : mdl

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic er);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 16)
    begin
      @(posedge mclk);
      k++;
    end
    if (k == 16)
      fails++;
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk(32'(er), 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(r, x);
    chk(32'(er), 32'(xe));
  endtask : rd

  // One CPU access, pins compared while valid, during hold and at idle
  task automatic acc(input logic [19:0] a, input int n, output int sc);
    int hc;
    hc = 0;
    sc = 0;
    // Start on the edge that ends E high, so E is high at the fourth edge
    @(posedge mclk);
    while (ecnt != 2'h3)
      @(posedge mclk);
    go <= 4'($urandom);
    goe <= 4'($urandom);
    caddr <= a;
    cval <= 1'b1;
    for (int i = 0; i < 48; i++)
    begin
      @(posedge mclk);
      if (i == 8)
        cval <= 1'b0;
      #1;
      if (hold === 1'b1)
        hc++;
      if (dev_sel === 1'b1)
        sc++;
      if (i == 3 || i == 47 || (i > 8 && hold === 1'b1))
        chk(32'({poeb, pout}), 32'(mdl(a, i != 47)));
    end
    chk(32'(hc > 0), 32'(n > 0));
  endtask : acc

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up;
  end

  // Main sequence
  initial
  begin
    int sc, pv;
    logic [19:0] at [3];
    at = '{20'h00800, 20'h01FFF, 20'h02000};
    void'($urandom(32'h5C3B5A58));
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    rd(CSDEC_CTRL_OFF, 32'h10, 1'b0);
    rd(CSDEC_STRETCH_OFF, 32'h0, 1'b0);
    rd(CSDEC_GP1_OFF, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    ctrl = 8'h13;
    wr(CSDEC_CTRL_OFF, 32'(ctrl));
    acc(20'h01000, 0, sc);
    acc(20'h0FFFE, 0, sc);
    expd <= 1'b1;
    repeat (5) @(posedge mclk);
    for (int s = 0; s < 4; s++)
    begin
      ctrl = {1'b0, 2'(s), 5'h10};
      wr(CSDEC_CTRL_OFF, 32'(ctrl));
      acc(20'(65536 - (65536 >> s)), 0, sc);
      if (s > 0)
        acc(20'(65535 - (65536 >> s)), 0, sc);
    end
    for (int m = 0; m < 8; m++)
    begin
      ctrl = {4'h1, 3'(m), 1'b1};
      wr(CSDEC_CTRL_OFF, 32'(ctrl));
      foreach (at[j])
        acc(at[j], 0, sc);
    end
    ctrl = 8'h10;
    wr(CSDEC_CTRL_OFF, 32'(ctrl));
    pv = 0;
    for (int n = 0; n < 4; n++)
    begin
      wr(CSDEC_STRETCH_OFF, 32'(n << 2));
      acc(20'h0FFFE, n, sc);
      if (n > 0)
        chk(32'(sc > pv), 32'h1);
      pv = sc;
    end
    wr(CSDEC_STRETCH_OFF, 32'h0);
    gp1 = 18'h3010F;
    wr(CSDEC_GP1_OFF, 32'(gp1));
    gp2 = 18'h10F08;
    wr(CSDEC_GP2_OFF, 32'(gp2));
    for (int p = 0; p < 2; p++)
    begin
      ctrl = {1'(p), 7'h10};
      wr(CSDEC_CTRL_OFF, 32'(ctrl));
      acc(20'h0FFFE, 0, sc);
      acc(20'h0EFFE, 0, sc);
    end
    gp1 = 18'h302FF;
    wr(CSDEC_GP1_OFF, 32'(gp1));
    acc(20'hFFFFE, 0, sc);
    rd(CSDEC_GP1_OFF, 32'(gp1), 1'b0);
    rd(CSDEC_GP2_OFF, 32'(gp2), 1'b0);
    rd(CSDEC_STATUS_OFF, 32'h1, 1'b0);
    wrap_up;
  end
endmodule : chip_select_decoder_tb_top
